// File: adc_ctrl_defines.vh
// constants for the continuous-conversion adc controller
// assumes inclusion by plain verilog-2005 design files
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ****************************************************************
// register byte addresses (apb, 32-bit aligned words)
// ****************************************************************
`define ADDR_CTL0       12'h000
`define ADDR_CTL1       12'h004
`define ADDR_RES_HI     12'h008
`define ADDR_RES_LO     12'h00C
`define ADDR_STATUS     12'h010
`define ADDR_CAL_IDX    12'h014
`define ADDR_CAL_DATA   12'h018

// ****************************************************************
// control register 0 fields
// ****************************************************************
`define CTL0_GO         7
`define CTL0_REFLO      6
`define CTL0_REFOUT     5
`define CTL0_REPEAT     4
`define CTL0_CH_HI      3
`define CTL0_RESET      8'h00

// ****************************************************************
// control register 1 fields
// ****************************************************************
`define CTL1_REFHI      7
`define CTL1_STAGE_HI   2
`define CTL1_RESET      8'h80

// ****************************************************************
// timing, offset-calibration channel code and calibration store size
// ****************************************************************
`define T_FIRST         13'h1409
`define T_REPEAT        13'h0100
`define T_POWERUP       13'h0028
`define T_IDLE_PD       8'hA0
`define CH_OFFSET_CAL   4'hF
`define CAL_BYTES       5'h1E
`define CAL_IDX_MAX     5'h1D

`endif

// File: adc_cal_store.v
// factory calibration byte store, 30 bytes, three per input mode
// assumes software loads it once from nonvolatile space over apb
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.vh"

module adc_cal_store (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // write port
    input  wire       wr_en,
    input  wire [4:0] wr_idx,
    input  wire [7:0] wr_data,
    // read port
    input  wire [4:0] rd_idx,
    output reg  [7:0] rd_data
);

    reg [7:0] mem_q [0:29];
    genvar i;

    // ****************************************************************
    // storage
    // ****************************************************************
    generate
        for (i = 0; i < 30; i = i + 1) begin : g_byte
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_q[i] <= 8'h00;
                end else if (wr_en && wr_idx == i) begin
                    mem_q[i] <= wr_data;
                end
            end
        end
    endgenerate

    // out-of-range index reads zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 8'h00;
        end else if (rd_idx <= `CAL_IDX_MAX) begin
            rd_data <= mem_q[rd_idx];
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// File: adc_continuous_conversion_ctrl.v
// sequencer and register file for a sigma-delta adc controller
// assumes an apb master on pclk and an analog front end giving samples
// What this block does
// - every new result overwrites result registers; nothing buffered
// - first conversion ends 5129 cycles after start, plus 40 if powered down
// - convert_go clears at first completion and stays 0 for the run
// - after the first, a new result every 256 cycles while repeating
// - 13-bit result: high byte holds [12:5], low byte [7:3] holds [4:0]
// - interrupt request after every completed conversion, first included
// - software writes repeat_conversion_select 0 to stop repeating
// - disabled converter raises no new interrupts; pending stays
// - channel code selecting offset calibration shorts differential inputs
// - thirty calibration bytes, three per input mode
// - result is sign, ten data bits and two calibration bits
// - overflow flag at word lsb marks data invalid
// - writing go 1 starts or restarts; writing 0 does nothing
// - 160 idle cycles power down; next request first takes 40 power-up cycles
// - differential channel code 1111 selects offset calibration
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.vh"

module adc_continuous_conversion_ctrl (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // analog front end
    input  wire [12:0] sample_value,
    input  wire        sample_ovf,
    output wire        adc_powered,
    output wire        inputs_shorted,
    output wire [3:0]  input_channel_select,
    output wire [2:0]  input_stage_select,
    output wire [1:0]  ref_level,
    output wire        ref_drive_out,
    // interrupt controller
    output reg         conv_done_irq
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_PWRUP = 2'b01;
    localparam [1:0] ST_FIRST = 2'b10;
    localparam [1:0] ST_REPT  = 2'b11;

    reg  [1:0]  state_q;
    reg  [12:0] cnt_q;
    reg  [7:0]  idle_q;
    reg         pwr_q;
    reg  [7:0]  ctl0_q;
    reg  [7:0]  ctl1_q;
    reg  [7:0]  res_hi_q;
    reg  [7:0]  res_lo_q;
    reg  [4:0]  cal_idx_q;
    reg         irq_pend_q;
    wire [7:0]  cal_rd;

    wire wr_access = psel && penable && pwrite;
    wire rd_access = psel && penable && !pwrite;
    wire ctl0_wr   = wr_access && paddr == `ADDR_CTL0;
    wire go_wr     = ctl0_wr && pwdata[`CTL0_GO];
    wire repeat_on = ctl0_q[`CTL0_REPEAT];
    wire done      = (state_q == ST_FIRST || state_q == ST_REPT) && cnt_q == 13'h0001;
    wire mapped    = paddr == `ADDR_CTL0 || paddr == `ADDR_CTL1 || paddr == `ADDR_RES_HI ||
                     paddr == `ADDR_RES_LO || paddr == `ADDR_STATUS ||
                     paddr == `ADDR_CAL_IDX || paddr == `ADDR_CAL_DATA;

    // single-cycle answer; unmapped reads zero and flags slverr
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ****************************************************************
    // front-end controls
    // ****************************************************************
    assign input_channel_select = ctl0_q[`CTL0_CH_HI:0];
    assign input_stage_select   = ctl1_q[`CTL1_STAGE_HI:0];
    assign ref_level            = {ctl1_q[`CTL1_REFHI], ctl0_q[`CTL0_REFLO]};
    assign ref_drive_out        = ctl0_q[`CTL0_REFOUT];
    assign adc_powered          = pwr_q;
    assign inputs_shorted       = input_channel_select == `CH_OFFSET_CAL;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q   <= 13'h0000;
        end else if (go_wr) begin
            // a go write restarts whatever is running
            if (pwr_q) begin
                state_q <= ST_FIRST;
                cnt_q   <= `T_FIRST;
            end else begin
                state_q <= ST_PWRUP;
                cnt_q   <= `T_POWERUP;
            end
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 13'h0000;
                end
                ST_PWRUP: begin
                    if (cnt_q == 13'h0001) begin
                        state_q <= ST_FIRST;
                        cnt_q   <= `T_FIRST;
                    end else begin
                        cnt_q <= cnt_q - 13'h0001;
                    end
                end
                default: begin
                    if (done) begin
                        if (repeat_on) begin
                            state_q <= ST_REPT;
                            cnt_q   <= `T_REPEAT;
                        end else begin
                            state_q <= ST_IDLE;
                            cnt_q   <= 13'h0000;
                        end
                    end else begin
                        cnt_q <= cnt_q - 13'h0001;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // idle power-down
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q  <= 1'b0;
            idle_q <= 8'h00;
        end else if (state_q != ST_IDLE || go_wr) begin
            idle_q <= 8'h00;
            if (state_q == ST_PWRUP && cnt_q == 13'h0001) begin
                pwr_q <= 1'b1;
            end
        end else if (idle_q == `T_IDLE_PD - 8'h01) begin
            pwr_q  <= 1'b0;
            idle_q <= 8'h00;
        end else if (pwr_q) begin
            idle_q <= idle_q + 8'h01;
        end
    end

    // ****************************************************************
    // results and interrupt
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_hi_q      <= 8'h00;
            res_lo_q      <= 8'h00;
            conv_done_irq <= 1'b0;
            irq_pend_q    <= 1'b0;
        end else begin
            conv_done_irq <= done && !go_wr;
            if (done && !go_wr) begin
                // overwrite; older result is lost on purpose
                res_hi_q   <= sample_value[12:5];
                res_lo_q   <= {sample_value[4:0], 2'b00, sample_ovf};
                irq_pend_q <= 1'b1;
            end else if (rd_access && paddr == `ADDR_STATUS) begin
                irq_pend_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_q    <= `CTL0_RESET;
            ctl1_q    <= `CTL1_RESET;
            cal_idx_q <= 5'h00;
        end else begin
            if (ctl0_wr) begin
                // go is set by a 1 write, never by a 0 write; a first completion clears it unless a 1 write lands in the same cycle
                ctl0_q <= {pwdata[`CTL0_GO] | (ctl0_q[`CTL0_GO] & !(state_q == ST_FIRST && done)),
                           pwdata[6:0]};
            end else if (state_q == ST_FIRST && done) begin
                ctl0_q[`CTL0_GO] <= 1'b0;
            end
            if (wr_access && paddr == `ADDR_CTL1) begin
                ctl1_q <= pwdata[7:0];
            end
            if (wr_access && paddr == `ADDR_CAL_IDX) begin
                cal_idx_q <= pwdata[4:0];
            end else if (wr_access && paddr == `ADDR_CAL_DATA && cal_idx_q < `CAL_IDX_MAX) begin
                cal_idx_q <= cal_idx_q + 5'h01;
            end
        end
    end

    adc_cal_store u_cal (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access && paddr == `ADDR_CAL_DATA),
        .wr_idx  (cal_idx_q),
        .wr_data (pwdata[7:0]),
        .rd_idx  (cal_idx_q),
        .rd_data (cal_rd)
    );

    // read mux
    always @* begin
        if (paddr == `ADDR_CTL0) begin
            prdata = {24'h000000, ctl0_q};
        end else if (paddr == `ADDR_CTL1) begin
            prdata = {24'h000000, ctl1_q};
        end else if (paddr == `ADDR_RES_HI) begin
            prdata = {24'h000000, res_hi_q};
        end else if (paddr == `ADDR_RES_LO) begin
            prdata = {24'h000000, res_lo_q};
        end else if (paddr == `ADDR_STATUS) begin
            prdata = {28'h0000000, pwr_q, state_q, irq_pend_q};
        end else if (paddr == `ADDR_CAL_IDX) begin
            prdata = {27'h0000000, cal_idx_q};
        end else if (paddr == `ADDR_CAL_DATA) begin
            prdata = {24'h000000, cal_rd};
        end else begin
            prdata = 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// File: adc_ctrl_sva.sv
// assertions on the adc controller ports
// assumes binding onto adc_continuous_conversion_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // front end and interrupt
    input wire logic        adc_powered,
    input wire logic        inputs_shorted,
    input wire logic [3:0]  input_channel_select,
    input wire logic        conv_done_irq
);
    // ********
    // helper counters
    // ********
    // gap starts saturated so the first completion is never judged short
    logic [13:0] gap_q;
    logic [13:0] go_cnt_q;
    logic        go_run_q;
    wire         go_wr = psel && penable && pwrite && paddr == 12'h000 && pwdata[7];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q    <= 14'h3FFF;
            go_cnt_q <= 14'h0000;
            go_run_q <= 1'b0;
        end else begin
            gap_q    <= conv_done_irq ? 14'h0001 : gap_q + {13'h0000, gap_q != 14'h3FFF};
            go_cnt_q <= go_wr ? 14'h0000 : go_cnt_q + 14'h0001;
            go_run_q <= go_wr || (go_run_q && !conv_done_irq);
        end
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_irq_high; conv_done_irq; endsequence
    sequence s_first_done; conv_done_irq && go_run_q; endsequence
    property p_irq_pulse; s_irq_high |=> !conv_done_irq; endproperty
    property p_irq_spacing; s_irq_high |-> gap_q >= 14'h0100; endproperty
    property p_first_latency; s_first_done |-> go_cnt_q == 14'h1409 || go_cnt_q == 14'h1431; endproperty
    property p_irq_powered; s_irq_high |-> adc_powered; endproperty
    property p_idle_pd; $fell(adc_powered) |-> gap_q >= 14'h00A0; endproperty
    property p_shorted; inputs_shorted == (input_channel_select == 4'hF); endproperty
    property p_ready; psel && penable |-> pready; endproperty
    property p_unmapped; psel && penable && paddr > 12'h018 |-> pslverr; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse too long");
    a_irq_spacing: assert property (p_irq_spacing) else $error("results too close");
    a_first_latency: assert property (p_first_latency) else $error("first result latency");
    a_irq_powered: assert property (p_irq_powered) else $error("result while unpowered");
    a_idle_pd: assert property (p_idle_pd) else $error("early power down");
    a_shorted: assert property (p_shorted) else $error("input short mismatch");
    a_ready: assert property (p_ready) else $error("wait state inserted");
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
endmodule

bind adc_continuous_conversion_ctrl adc_ctrl_sva adc_ctrl_sva_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .adc_powered, .inputs_shorted, .input_channel_select, .conv_done_irq);
`default_nettype wire

// File: adc_continuous_conversion_ctrl_test.sv
// self-checking bench for the continuous-conversion adc controller
// assumes the design files and the checker file are compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_continuous_conversion_ctrl_test;
    logic        pclk, presetn, psel, penable, pwrite, sample_ovf, err;
    logic        pready, pslverr, adc_powered, inputs_shorted, ref_drive_out, conv_done_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] sample_value;
    logic [3:0]  input_channel_select;
    logic [2:0]  input_stage_select;
    logic [1:0]  ref_level;
    int          miscompares = 0, num_checks = 0, cyc = 0, t1, tirq, scaled;
    logic [7:0]  cal [3];
    logic signed [15:0] adcw, offw, gain;
    logic signed [31:0] diff, comp;

    adc_continuous_conversion_ctrl adc_continuous_conversion_ctrl_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sample_value, .sample_ovf, .adc_powered, .inputs_shorted, .input_channel_select,
        .input_stage_select, .ref_level, .ref_drive_out, .conv_done_irq);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // latencies are differences of this count
    always @(posedge pclk) cyc <= cyc + 1;

    // ********
    // tasks
    // ********
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask

    task summarize;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // leading edge so no signal is assigned twice in one time step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            $display("wrong value at %0t: no pready", $time);
            miscompares++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_irq(input int base, input int exp);
        int i;
        for (i = 0; i < 6000 && conv_done_irq !== 1'b1; i++)
            @(posedge pclk);
        if (i == 6000) begin
            $display("wrong value at %0t: no interrupt", $time);
            miscompares++;
            summarize();
        end
        tirq = cyc;
        chk(tirq - base, exp);
    endtask

    task chk_res(input logic [12:0] v, input logic o);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, {24'h0, v[12:5]});
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, {24'h0, v[4:0], 2'b00, o});
    endtask

    // ********
    // sequence
    // ********
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample_value = 13'h1A5B;
        sample_ovf = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h80);
        chk(adc_powered, 1'b0);
        apb(1'b1, 12'h020, 32'h5A);
        chk(err, 1'b1);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h004, 32'h05);
        apb(1'b1, 12'h000, 32'hFF);
        t1 = cyc;
        @(posedge pclk);
        chk({ref_level, ref_drive_out, inputs_shorted, input_channel_select}, 8'h7F);
        chk(input_stage_select, 3'h5);
        wait_irq(t1, 5170);
        chk(adc_powered, 1'b1);
        chk_res(13'h1A5B, 1'b0);
        for (int k = 0; k < 3; k++) begin
            t1 = tirq;
            sample_value <= {k[2:0], 10'h2C3};
            sample_ovf <= k[0];
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, 32'h7F);
            if (k == 1) apb(1'b1, 12'h000, 32'h7F);
            wait_irq(t1, 256);
            chk_res({k[2:0], 10'h2C3}, k[0]);
        end
        sample_value <= 13'h0100;
        // stop, then restart while still powered
        apb(1'b1, 12'h000, 32'h6F);
        wait_irq(tirq, 256);
        apb(1'b1, 12'h000, 32'hFF);
        repeat (300) @(posedge pclk);
        apb(1'b1, 12'h000, 32'hFF);
        t1 = cyc;
        wait_irq(t1, 5130);
        apb(1'b1, 12'h000, 32'h6F);
        wait_irq(tirq, 256);
        for (int k = 0; k < 300; k++) begin
            @(posedge pclk);
            chk(conv_done_irq, 1'b0);
        end
        chk(adc_powered, 1'b0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        // calibration store: three bytes, index walks on by itself
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, 12'h018, 32'h04);
        apb(1'b1, 12'h018, 32'h20);
        apb(1'b1, 12'h018, 32'h00);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h3);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 12'h014, k);
            apb(1'b0, 12'h018, 32'h0);
            cal[k] = rd[7:0];
        end
        chk({cal[0], cal[1], cal[2]}, 32'h00042000);
        // index stops at the last byte; beyond it reads zero
        apb(1'b1, 12'h014, 32'h1D);
        apb(1'b1, 12'h018, 32'h77);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h1D);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h77);
        apb(1'b1, 12'h014, 32'h1F);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0);
        // software compensation on the last stored result
        chk_res(13'h0100, 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        adcw[15:8] = rd[7:0];
        apb(1'b0, 12'h00C, 32'h0);
        adcw[7:0] = {rd[7:3], 3'b000};
        offw = {{5{cal[0][7]}}, cal[0], 3'b000};
        gain = {cal[1], cal[2]};
        diff = adcw - offw;
        comp = diff + diff * gain / 32'sh00010000;
        chk(comp, 32'h000008DC);
        scaled = adcw[15:3] * 8 / 7;
        chk(scaled, 32'h00000124);
        summarize();
    end
endmodule
`default_nettype wire
